//--- logic/mgc_consts.vh
`ifndef MGC_CONSTS_VH
`define MGC_CONSTS_VH
// Register offsets
`define MGC_ADDR_GLOBAL_CONTROL  8'h02
`define MGC_ADDR_BERT_CONNECT    8'h03
`define MGC_ADDR_SERIAL_CLK_ACT  8'h04
`define MGC_ADDR_REF_SYS_CLK_ACT 8'h05
`define MGC_ADDR_SERIAL_IRQ_EN   8'h06
`define MGC_ADDR_SERIAL_IRQ_ST   8'h07
`define MGC_ADDR_ETH_IRQ_EN      8'h08
`define MGC_ADDR_ETH_IRQ_ST      8'h09
`define MGC_ADDR_QUEUE_IRQ_EN    8'h0a
`define MGC_ADDR_QUEUE_IRQ_ST    8'h0b
`define MGC_ADDR_BERT_IRQ_EN     8'h0c
`define MGC_ADDR_BERT_IRQ_ST     8'h0d
`define MGC_ADDR_CONNECTION      8'h0e
`define MGC_ADDR_QPTR_RESET      8'h12
// Field positions
`define MGC_BIT_SOFT_RESET       0
`define MGC_BIT_IRQ_IDLE_DRIVE   1
`define MGC_BIT_REFCLK_DISABLE   2
`define MGC_BIT_BERT_CONNECT     0
`define MGC_BIT_RX_SERIAL_CLK    4
`define MGC_BIT_TX_SERIAL_CLK    0
`define MGC_BIT_REF_CLK_SEEN     1
`define MGC_BIT_SYS_CLK_SEEN     0
`define MGC_BIT_TX_SIDE          4
`define MGC_BIT_RX_SIDE          0
`define MGC_BIT_ETH              0
`define MGC_BIT_BERT             0
`define MGC_BIT_CONNECT_SEL      0
`define MGC_BIT_RXQ_RD_CLR       3
`define MGC_BIT_RXQ_WR_CLR       2
// Reset values
`define MGC_RST_CONTROL          8'h00
`define MGC_RST_CONNECTION       8'h01
// Timing
`define MGC_SOFT_RESET_MIN_NS    100
`define MGC_CLK_PERIOD_NS        10
`endif

//--- logic/mgc_sync2.v
`timescale 1ns/1ps
// ==========================================
// Two flop synchroniser
module mgc_sync2 (
	input  wire clk,
	input  wire rst,
	input  wire din,
	output reg  dout
);
	reg stage1;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b0;
			dout   <= 1'b0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule

//--- logic/mgc_activity.v
`timescale 1ns/1ps
// ==========================================
// Sticky activity latch: sees edges of a synchronised clock, clears on read
module mgc_activity (
	input  wire clk,
	input  wire rst,
	input  wire srst,
	input  wire pin,
	input  wire clear,
	output reg  seen
);
	wire sync_level;
	reg  last_level;
	mgc_sync2 u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  (pin),
		.dout (sync_level)
	);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			last_level <= 1'b0;
			seen       <= 1'b0;
		end else if (srst) begin
			last_level <= sync_level;
			seen       <= 1'b0;
		end else begin
			last_level <= sync_level;
			// Set wins over a read clear in the same cycle
			if (sync_level != last_level)
				seen <= 1'b1;
			else if (clear)
				seen <= 1'b0;
		end
	end
endmodule

//--- logic/mgc_global_regs.v
`timescale 1ns/1ps
`include "mgc_consts.vh"
// ==========================================
// Global control and status registers
module mgc_global_regs (
	input  wire       clk,
	input  wire       rst,
	input  wire [7:0] addr,
	input  wire [7:0] wdata,
	input  wire       cs_n,
	input  wire       wr_n,
	input  wire       rd_n,
	output reg  [7:0] rdata,
	input  wire       ref_clock_pin,
	input  wire       mode_clock,
	input  wire       system_clock_input,
	input  wire       rx_serial_clock,
	input  wire       tx_serial_clock,
	input  wire       serial_tx_event,
	input  wire       serial_rx_event,
	input  wire       ethernet_event,
	input  wire       tx_queue_event,
	input  wire       rx_queue_event,
	input  wire       bert_event,
	input  wire       hdlc_tx_data,
	input  wire       bert_tx_data,
	input  wire       serial_rx_data,
	output reg        serial_tx_data,
	output reg        hdlc_rx_data,
	output reg        bert_rx_data,
	output reg        hdlc_clock_enable,
	output reg        reference_clock_output,
	output reg        irq_n_out,
	output reg        irq_n_oe,
	output reg        datapath_reset,
	output reg        rx_queue_read_ptr_clear,
	output reg        rx_queue_write_ptr_clear
);
	localparam integer SRST_MIN_CYCLES =
		(`MGC_SOFT_RESET_MIN_NS + `MGC_CLK_PERIOD_NS - 1) / `MGC_CLK_PERIOD_NS;
	localparam [7:0]   CONN_RST        = `MGC_RST_CONNECTION;

	// ==========================================
	// Bus strobes: synchronise, write on the falling edge of the write strobe, read clear on the rising edge of the read strobe
	wire cs_s;
	wire wr_s;
	wire rd_s;
	reg  wr_d;
	reg  rd_d;
	reg  [7:0] rd_addr;
	wire [7:0] addr_s;
	wire [7:0] wdata_s;
	mgc_sync2 u_cs (.clk(clk), .rst(rst), .din(~cs_n), .dout(cs_s));
	mgc_sync2 u_wr (.clk(clk), .rst(rst), .din(~wr_n), .dout(wr_s));
	mgc_sync2 u_rd (.clk(clk), .rst(rst), .din(~rd_n), .dout(rd_s));
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_bus
			mgc_sync2 u_a (.clk(clk), .rst(rst), .din(addr[gi]), .dout(addr_s[gi]));
			mgc_sync2 u_d (.clk(clk), .rst(rst), .din(wdata[gi]), .dout(wdata_s[gi]));
		end
	endgenerate
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_d    <= 1'b0;
			rd_d    <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			wr_d <= wr_s & cs_s;
			rd_d <= rd_s & cs_s;
			// Host may drop the address with the strobe, so the clear uses this copy
			if (rd_s & cs_s)
				rd_addr <= addr_s;
		end
	end
	wire wr_pulse = wr_s & cs_s & ~wr_d;
	wire rd_end   = rd_d & ~(rd_s & cs_s);

	// ==========================================
	// Registers
	reg       soft_reset;
	reg       irq_idle_drive_select;
	reg       refclk_disable;
	reg       bert_connect_bit;
	reg       serial_tx_irq_enable;
	reg       serial_rx_irq_enable;
	reg       ethernet_irq_enable_bit;
	reg       tx_queue_irq_enable;
	reg       rx_queue_irq_enable;
	reg       bert_irq_enable_bit;
	reg       serial_tx_irq_flag;
	reg       serial_rx_irq_flag;
	reg       ethernet_irq_flag;
	reg       tx_queue_irq_flag;
	reg       rx_queue_irq_flag;
	reg       bert_irq_flag;
	reg       connection_select_bit;
	reg [1:0] qptr_bits;
	reg [3:0] srst_count;

	wire wr_ctl = wr_pulse && addr_s == `MGC_ADDR_GLOBAL_CONTROL;

	// Soft reset bit itself is untouched by its own reset
	always @(posedge clk or posedge rst) begin
		if (rst)
			soft_reset <= 1'b0;
		else if (wr_ctl)
			soft_reset <= wdata_s[`MGC_BIT_SOFT_RESET];
	end

	// Internal reset stretched to the minimum width even if host is short
	always @(posedge clk or posedge rst) begin
		if (rst)
			srst_count <= 4'h0;
		else if (soft_reset)
			srst_count <= SRST_MIN_CYCLES[3:0];
		else if (srst_count != 4'h0)
			srst_count <= srst_count - 4'h1;
	end
	wire srst = soft_reset | (srst_count != 4'h0);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_idle_drive_select   <= 1'b0;
			refclk_disable          <= 1'b0;
			bert_connect_bit        <= 1'b0;
			serial_tx_irq_enable    <= 1'b0;
			serial_rx_irq_enable    <= 1'b0;
			ethernet_irq_enable_bit <= 1'b0;
			tx_queue_irq_enable     <= 1'b0;
			rx_queue_irq_enable     <= 1'b0;
			bert_irq_enable_bit     <= 1'b0;
			connection_select_bit   <= 1'b1;
			qptr_bits               <= 2'b00;
		end else if (srst) begin
			irq_idle_drive_select   <= 1'b0;
			refclk_disable          <= 1'b0;
			bert_connect_bit        <= 1'b0;
			serial_tx_irq_enable    <= 1'b0;
			serial_rx_irq_enable    <= 1'b0;
			ethernet_irq_enable_bit <= 1'b0;
			tx_queue_irq_enable     <= 1'b0;
			rx_queue_irq_enable     <= 1'b0;
			bert_irq_enable_bit     <= 1'b0;
			connection_select_bit   <= CONN_RST[`MGC_BIT_CONNECT_SEL];
			qptr_bits               <= 2'b00;
		end else if (wr_pulse) begin
			case (addr_s)
				`MGC_ADDR_GLOBAL_CONTROL: begin
					irq_idle_drive_select <= wdata_s[`MGC_BIT_IRQ_IDLE_DRIVE];
					refclk_disable        <= wdata_s[`MGC_BIT_REFCLK_DISABLE];
				end
				`MGC_ADDR_BERT_CONNECT:
					bert_connect_bit <= wdata_s[`MGC_BIT_BERT_CONNECT];
				`MGC_ADDR_SERIAL_IRQ_EN: begin
					serial_tx_irq_enable <= wdata_s[`MGC_BIT_TX_SIDE];
					serial_rx_irq_enable <= wdata_s[`MGC_BIT_RX_SIDE];
				end
				`MGC_ADDR_ETH_IRQ_EN:
					ethernet_irq_enable_bit <= wdata_s[`MGC_BIT_ETH];
				`MGC_ADDR_QUEUE_IRQ_EN: begin
					tx_queue_irq_enable <= wdata_s[`MGC_BIT_TX_SIDE];
					rx_queue_irq_enable <= wdata_s[`MGC_BIT_RX_SIDE];
				end
				`MGC_ADDR_BERT_IRQ_EN:
					bert_irq_enable_bit <= wdata_s[`MGC_BIT_BERT];
				`MGC_ADDR_CONNECTION:
					connection_select_bit <= wdata_s[`MGC_BIT_CONNECT_SEL];
				`MGC_ADDR_QPTR_RESET:
					qptr_bits <= {wdata_s[`MGC_BIT_RXQ_RD_CLR], wdata_s[`MGC_BIT_RXQ_WR_CLR]};
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// Second level status: follows source event levels (source holds them)
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_tx_irq_flag <= 1'b0;
			serial_rx_irq_flag <= 1'b0;
			ethernet_irq_flag  <= 1'b0;
			tx_queue_irq_flag  <= 1'b0;
			rx_queue_irq_flag  <= 1'b0;
			bert_irq_flag      <= 1'b0;
		end else if (srst) begin
			serial_tx_irq_flag <= 1'b0;
			serial_rx_irq_flag <= 1'b0;
			ethernet_irq_flag  <= 1'b0;
			tx_queue_irq_flag  <= 1'b0;
			rx_queue_irq_flag  <= 1'b0;
			bert_irq_flag      <= 1'b0;
		end else begin
			serial_tx_irq_flag <= serial_tx_event;
			serial_rx_irq_flag <= serial_rx_event;
			ethernet_irq_flag  <= ethernet_event;
			tx_queue_irq_flag  <= tx_queue_event;
			rx_queue_irq_flag  <= rx_queue_event;
			bert_irq_flag      <= bert_event;
		end
	end

	// ==========================================
	// Clock activity latches
	wire rx_serial_clock_seen;
	wire tx_serial_clock_seen;
	wire ref_clock_seen;
	wire system_clock_seen;
	wire rd_serial_act = rd_end && rd_addr == `MGC_ADDR_SERIAL_CLK_ACT;
	wire rd_refsys_act = rd_end && rd_addr == `MGC_ADDR_REF_SYS_CLK_ACT;
	mgc_activity u_rx_act (.clk(clk), .rst(rst), .srst(srst), .pin(rx_serial_clock),
		.clear(rd_serial_act), .seen(rx_serial_clock_seen));
	mgc_activity u_tx_act (.clk(clk), .rst(rst), .srst(srst), .pin(tx_serial_clock),
		.clear(rd_serial_act), .seen(tx_serial_clock_seen));
	mgc_activity u_ref_act (.clk(clk), .rst(rst), .srst(srst), .pin(ref_clock_pin),
		.clear(rd_refsys_act), .seen(ref_clock_seen));
	mgc_activity u_sys_act (.clk(clk), .rst(rst), .srst(srst), .pin(system_clock_input),
		.clear(rd_refsys_act), .seen(system_clock_seen));

	// ==========================================
	// Read data
	reg [7:0] next_rdata;
	always @* begin
		next_rdata = 8'h00;
		case (addr_s)
			`MGC_ADDR_GLOBAL_CONTROL: begin
				next_rdata[`MGC_BIT_SOFT_RESET]     = soft_reset;
				next_rdata[`MGC_BIT_IRQ_IDLE_DRIVE] = irq_idle_drive_select;
				next_rdata[`MGC_BIT_REFCLK_DISABLE] = refclk_disable;
			end
			`MGC_ADDR_BERT_CONNECT:
				next_rdata[`MGC_BIT_BERT_CONNECT] = bert_connect_bit;
			`MGC_ADDR_SERIAL_CLK_ACT: begin
				next_rdata[`MGC_BIT_RX_SERIAL_CLK] = rx_serial_clock_seen;
				next_rdata[`MGC_BIT_TX_SERIAL_CLK] = tx_serial_clock_seen;
			end
			`MGC_ADDR_REF_SYS_CLK_ACT: begin
				next_rdata[`MGC_BIT_REF_CLK_SEEN] = ref_clock_seen;
				next_rdata[`MGC_BIT_SYS_CLK_SEEN] = system_clock_seen;
			end
			`MGC_ADDR_SERIAL_IRQ_EN: begin
				next_rdata[`MGC_BIT_TX_SIDE] = serial_tx_irq_enable;
				next_rdata[`MGC_BIT_RX_SIDE] = serial_rx_irq_enable;
			end
			`MGC_ADDR_SERIAL_IRQ_ST: begin
				next_rdata[`MGC_BIT_TX_SIDE] = serial_tx_irq_flag;
				next_rdata[`MGC_BIT_RX_SIDE] = serial_rx_irq_flag;
			end
			`MGC_ADDR_ETH_IRQ_EN:
				next_rdata[`MGC_BIT_ETH] = ethernet_irq_enable_bit;
			`MGC_ADDR_ETH_IRQ_ST:
				next_rdata[`MGC_BIT_ETH] = ethernet_irq_flag;
			`MGC_ADDR_QUEUE_IRQ_EN: begin
				next_rdata[`MGC_BIT_TX_SIDE] = tx_queue_irq_enable;
				next_rdata[`MGC_BIT_RX_SIDE] = rx_queue_irq_enable;
			end
			`MGC_ADDR_QUEUE_IRQ_ST: begin
				next_rdata[`MGC_BIT_TX_SIDE] = tx_queue_irq_flag;
				next_rdata[`MGC_BIT_RX_SIDE] = rx_queue_irq_flag;
			end
			`MGC_ADDR_BERT_IRQ_EN:
				next_rdata[`MGC_BIT_BERT] = bert_irq_enable_bit;
			`MGC_ADDR_BERT_IRQ_ST:
				next_rdata[`MGC_BIT_BERT] = bert_irq_flag;
			`MGC_ADDR_CONNECTION:
				next_rdata[`MGC_BIT_CONNECT_SEL] = connection_select_bit;
			`MGC_ADDR_QPTR_RESET: begin
				next_rdata[`MGC_BIT_RXQ_RD_CLR] = qptr_bits[1];
				next_rdata[`MGC_BIT_RXQ_WR_CLR] = qptr_bits[0];
			end
			default:
				next_rdata = 8'h00;
		endcase
	end

	// ==========================================
	// Interrupt and data path outputs
	wire irq_any = (serial_tx_irq_flag & serial_tx_irq_enable) |
		(serial_rx_irq_flag & serial_rx_irq_enable) |
		(ethernet_irq_flag & ethernet_irq_enable_bit) |
		(tx_queue_irq_flag & tx_queue_irq_enable) |
		(rx_queue_irq_flag & rx_queue_irq_enable) |
		(bert_irq_flag & bert_irq_enable_bit);

	wire mode_clock_s;
	mgc_sync2 u_mode (.clk(clk), .rst(rst), .din(mode_clock), .dout(mode_clock_s));

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata                    <= 8'h00;
			irq_n_out                <= 1'b1;
			irq_n_oe                 <= 1'b1;
			reference_clock_output   <= 1'b0;
			serial_tx_data           <= 1'b1;
			hdlc_rx_data             <= 1'b1;
			bert_rx_data             <= 1'b1;
			hdlc_clock_enable        <= 1'b0;
			datapath_reset           <= 1'b1;
			rx_queue_read_ptr_clear  <= 1'b0;
			rx_queue_write_ptr_clear <= 1'b0;
		end else begin
			rdata           <= next_rdata;
			// Low while asserted; idle drives high or floats
			irq_n_out <= ~irq_any;
			irq_n_oe  <= irq_any | ~irq_idle_drive_select;
			reference_clock_output <= refclk_disable ? 1'b0 : mode_clock_s;
			if (bert_connect_bit) begin
				serial_tx_data <= bert_tx_data;
				hdlc_rx_data   <= 1'b1;
				bert_rx_data   <= serial_rx_data;
			end else if (connection_select_bit) begin
				serial_tx_data <= hdlc_tx_data;
				hdlc_rx_data   <= serial_rx_data;
				bert_rx_data   <= 1'b1;
			end else begin
				serial_tx_data <= 1'b1;
				hdlc_rx_data   <= 1'b1;
				bert_rx_data   <= 1'b1;
			end
			hdlc_clock_enable        <= connection_select_bit & ~bert_connect_bit & ~srst;
			datapath_reset           <= srst;
			rx_queue_read_ptr_clear  <= qptr_bits[1];
			rx_queue_write_ptr_clear <= qptr_bits[0];
		end
	end
endmodule

//--- verification/mgc_host.sv
`timescale 1ns/1ps
// ==========================================
// Host processor on the parallel register port
module mgc_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr  = 8'hff,
	output logic      [7:0] wdata = 8'hff,
	output logic            cs_n  = 1'b1,
	output logic            wr_n  = 1'b1,
	output logic            rd_n  = 1'b1
);
	// Released lines show the inverse so a stale value is never seen
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		cs_n  <= 1'b0;
		wr_n  <= 1'b0;
		repeat (6) @(posedge clk);
		cs_n  <= 1'b1;
		wr_n  <= 1'b1;
		addr  <= ~a;
		wdata <= ~v;
		repeat (4) @(posedge clk);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (5) @(posedge clk);
		v = rdata;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		addr <= ~a;
		repeat (6) @(posedge clk);
	endtask
	// Both receive pointers pulsed, then cleared for the next use
	task ptr_reset;
		wr(8'h12, 8'h0c);
		wr(8'h12, 8'h00);
	endtask
endmodule

//--- verification/mgc_checker_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the global register block
module mgc_checker (
	input wire       clk,
	input wire       rst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       cs_n,
	input wire       wr_n,
	input wire       serial_tx_event,
	input wire       serial_rx_event,
	input wire       ethernet_event,
	input wire       tx_queue_event,
	input wire       rx_queue_event,
	input wire       bert_event,
	input wire       bert_tx_data,
	input wire       serial_rx_data,
	input wire       serial_tx_data,
	input wire       hdlc_rx_data,
	input wire       bert_rx_data,
	input wire       hdlc_clock_enable,
	input wire       reference_clock_output,
	input wire       irq_n_out,
	input wire       irq_n_oe,
	input wire       datapath_reset,
	input wire       rx_queue_read_ptr_clear
);
	// ==========================================
	// Shadow of host writes, updated early so windows below cover the lag
	reg  [7:0] ctl, brt, ie6, ie8, iea, iec, con;
	wire       wstb = !cs_n && !wr_n;
	wire       pend = serial_tx_event & ie6[4] | serial_rx_event & ie6[0] | ethernet_event & ie8[0]
	                | tx_queue_event & iea[4] | rx_queue_event & iea[0] | bert_event & iec[0];
	always @(posedge clk or posedge rst) begin
		if (rst || wstb && addr == 8'h02 && wdata[0]) begin
			ctl <= rst ? 8'h00 : 8'h01;
			brt <= 8'h00;
			ie6 <= 8'h00;
			ie8 <= 8'h00;
			iea <= 8'h00;
			iec <= 8'h00;
			con <= 8'h01;
		end else if (wstb && !ctl[0]) begin
			case (addr)
			8'h02: ctl <= wdata;
			8'h03: brt <= wdata;
			8'h06: ie6 <= wdata;
			8'h08: ie8 <= wdata;
			8'h0a: iea <= wdata;
			8'h0c: iec <= wdata;
			8'h0e: con <= wdata;
			default: ;
			endcase
		end else if (wstb && addr == 8'h02) begin
			ctl <= wdata;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_float;
		ctl[1] [*6];
	endsequence
	sequence s_bert;
		brt[0] [*6];
	endsequence
	a_irq_low_drives: assert property (!irq_n_out |-> irq_n_oe)
		else $error("irq asserted but not driven");
	a_irq_idle_float: assert property (s_float ##0 irq_n_out |-> !irq_n_oe)
		else $error("idle irq driven in float mode");
	a_irq_pending: assert property (pend [*8] |-> !irq_n_out)
		else $error("enabled event without irq");
	a_irq_quiet: assert property (!pend [*8] |-> irq_n_out)
		else $error("irq without enabled event");
	a_refclk_held: assert property (ctl[2] [*6] |-> !reference_clock_output)
		else $error("reference clock runs while disabled");
	a_disc_ones: assert property ((!con[0] && !brt[0]) [*6] |-> serial_tx_data && hdlc_rx_data && !hdlc_clock_enable)
		else $error("disconnected path not idle");
	a_bert_route: assert property (s_bert |-> serial_tx_data == $past(bert_tx_data)
		&& bert_rx_data == $past(serial_rx_data) && !hdlc_clock_enable)
		else $error("bert path not routed");
	a_ptr_by_write: assert property ($changed(rx_queue_read_ptr_clear) |-> $past(wstb, 2))
		else $error("pointer clear moved without write");
	a_reset_quiet: assert property (datapath_reset ##1 datapath_reset |-> !hdlc_clock_enable && !rx_queue_read_ptr_clear)
		else $error("state kept during reset");
endmodule

bind mgc_global_regs mgc_checker mgc_checker_inst (
	.clk                     (clk),
	.rst                     (rst),
	.addr                    (addr),
	.wdata                   (wdata),
	.cs_n                    (cs_n),
	.wr_n                    (wr_n),
	.serial_tx_event         (serial_tx_event),
	.serial_rx_event         (serial_rx_event),
	.ethernet_event          (ethernet_event),
	.tx_queue_event          (tx_queue_event),
	.rx_queue_event          (rx_queue_event),
	.bert_event              (bert_event),
	.bert_tx_data            (bert_tx_data),
	.serial_rx_data          (serial_rx_data),
	.serial_tx_data          (serial_tx_data),
	.hdlc_rx_data            (hdlc_rx_data),
	.bert_rx_data            (bert_rx_data),
	.hdlc_clock_enable       (hdlc_clock_enable),
	.reference_clock_output  (reference_clock_output),
	.irq_n_out               (irq_n_out),
	.irq_n_oe                (irq_n_oe),
	.datapath_reset          (datapath_reset),
	.rx_queue_read_ptr_clear (rx_queue_read_ptr_clear)
);

//--- verification/tb.sv
`timescale 1ns/1ps
// ==========================================
// Testbench
module tb;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       mode_clock = 1'b0;
	logic       htx = 1'b0;
	logic       btx = 1'b1;
	logic       srx = 1'b0;
	logic [3:0] ck = 4'h0;
	logic [5:0] ev = 6'h00;
	logic [7:0] rdata, addr, wdata, d, cnt;
	wire        cs_n, wr_n, rd_n, stx, hrx, brx, hce, rco, irq_o, irq_e, dpr, qrc, qwc;
	int         err_count = 0;
	int         n_tests = 0;
	logic [7:0] ra [0:12] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h12, 8'h13};
	logic [7:0] wa [0:9] = '{8'h03, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h07, 8'h09, 8'h0b, 8'h0d, 8'h13};
	logic [7:0] wm [0:9] = '{8'h01, 8'h11, 8'h01, 8'h11, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] aa [0:3] = '{8'h04, 8'h04, 8'h05, 8'h05};
	logic [7:0] am [0:3] = '{8'h01, 8'h10, 8'h02, 8'h01};
	logic [7:0] ea [0:5] = '{8'h06, 8'h06, 8'h08, 8'h0a, 8'h0a, 8'h0c};
	logic [7:0] em [0:5] = '{8'h10, 8'h01, 8'h01, 8'h10, 8'h01, 8'h01};
	always #5 clk = ~clk;
	always @(posedge clk) mode_clock <= ~mode_clock;
	mgc_host mgc_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n));
	mgc_global_regs mgc_global_regs_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .rdata(rdata), .ref_clock_pin(ck[2]), .mode_clock(mode_clock),
		.system_clock_input(ck[3]), .rx_serial_clock(ck[1]), .tx_serial_clock(ck[0]), .serial_tx_event(ev[0]),
		.serial_rx_event(ev[1]), .ethernet_event(ev[2]), .tx_queue_event(ev[3]), .rx_queue_event(ev[4]),
		.bert_event(ev[5]), .hdlc_tx_data(htx), .bert_tx_data(btx), .serial_rx_data(srx), .serial_tx_data(stx),
		.hdlc_rx_data(hrx), .bert_rx_data(brx), .hdlc_clock_enable(hce), .reference_clock_output(rco),
		.irq_n_out(irq_o), .irq_n_oe(irq_e), .datapath_reset(dpr), .rx_queue_read_ptr_clear(qrc),
		.rx_queue_write_ptr_clear(qwc));
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		mgc_host_inst.rd(a, d);
		check($sformatf("reg %h", a), d, e);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task count_ref;
		cnt = 8'h00;
		repeat (16) begin
			wt(1);
			cnt = cnt + 8'(rco);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		err_count = err_count + 1;
		print_verdict;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 13; i++) rc(ra[i], (ra[i] == 8'h0e) ? 8'h01 : 8'h00);
		for (int i = 0; i < 10; i++) begin
			mgc_host_inst.wr(wa[i], 8'hff);
			rc(wa[i], wm[i]);
			mgc_host_inst.wr(wa[i], 8'h00);
		end
		for (int k = 0; k < 4; k++) begin
			mgc_host_inst.rd(aa[k], d);
			repeat (4) begin
				@(posedge clk);
				ck[k] <= ~ck[k];
			end
			rc(aa[k], am[k]);
			rc(aa[k], 8'h00);
		end
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			ev[k] <= 1'b1;
			rc(ea[k] + 8'h01, em[k]);
			check("irq masked", 8'(irq_o), 8'h01);
			mgc_host_inst.wr(ea[k], em[k]);
			wt(2);
			check("irq raised", 8'(irq_o), 8'h00);
			@(posedge clk);
			ev[k] <= 1'b0;
			wt(4);
			check("irq released", 8'(irq_o), 8'h01);
			mgc_host_inst.wr(ea[k], 8'h00);
		end
		mgc_host_inst.wr(8'h06, 8'h10);
		mgc_host_inst.wr(8'h02, 8'h02);
		wt(1);
		check("irq float", 8'({irq_o, irq_e}), 8'h02);
		@(posedge clk);
		ev[0] <= 1'b1;
		wt(4);
		check("irq drive", 8'({irq_o, irq_e}), 8'h01);
		@(posedge clk);
		ev[0] <= 1'b0;
		mgc_host_inst.wr(8'h02, 8'h04);
		count_ref;
		check("refclk off", cnt, 8'h00);
		mgc_host_inst.wr(8'h02, 8'h00);
		count_ref;
		check("refclk on", cnt, 8'h08);
		mgc_host_inst.wr(8'h06, 8'h00);
		mgc_host_inst.wr(8'h12, 8'h0c);
		check("ptr clear", 8'({qrc, qwc}), 8'h03);
		rc(8'h12, 8'h0c);
		mgc_host_inst.wr(8'h12, 8'h00);
		check("ptr idle", 8'({qrc, qwc}), 8'h00);
		wt(1);
		check("connected", 8'({stx, hrx, hce}), 8'h01);
		@(posedge clk);
		htx <= 1'b1;
		btx <= 1'b0;
		mgc_host_inst.wr(8'h03, 8'h01);
		wt(1);
		check("bert", 8'({stx, brx, hce}), 8'h00);
		@(posedge clk);
		htx <= 1'b0;
		mgc_host_inst.wr(8'h03, 8'h00);
		wt(1);
		check("restored", 8'({stx, hce}), 8'h01);
		mgc_host_inst.wr(8'h0e, 8'h00);
		wt(1);
		check("disconnected", 8'({stx, hrx, hce}), 8'h06);
		mgc_host_inst.ptr_reset;
		mgc_host_inst.wr(8'h0e, 8'h01);
		wt(1);
		check("reconnected", 8'(hce), 8'h01);
		mgc_host_inst.wr(8'h06, 8'h11);
		mgc_host_inst.wr(8'h0e, 8'h00);
		mgc_host_inst.wr(8'h03, 8'h01);
		mgc_host_inst.wr(8'h02, 8'h01);
		check("soft reset", 8'(dpr), 8'h01);
		mgc_host_inst.wr(8'h06, 8'h11);
		mgc_host_inst.wr(8'h02, 8'h00);
		wt(12);
		rc(8'h06, 8'h00);
		rc(8'h0e, 8'h01);
		rc(8'h03, 8'h00);
		rc(8'h02, 8'h00);
		print_verdict;
	end
endmodule
